// *** hdl/codec_pkg.sv ***
// Shared constants and types for the codec frame control decoder
`default_nettype none
package codec_pkg;
  // Timing in its own units, cycle counts derived from the clock period
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SAMPLE_PERIOD_NS = 125000;
  localparam int unsigned FRAME_CYCLES_DEF = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned BIT_PERIOD_NS    = 80;
  localparam int unsigned BIT_CYCLES_INT   =
    (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter widths
  localparam int unsigned FCNT_W  = 16;
  localparam int unsigned DIV_W   = 4;
  localparam int unsigned BITN_W  = 5;
  localparam int unsigned PHASE_W = 8;
  localparam int unsigned ADDR_W  = 8;

  localparam logic [DIV_W-1:0]  BIT_LAST  = DIV_W'(BIT_CYCLES_INT - 1);
  localparam logic [DIV_W-1:0]  BIT_HALF  = DIV_W'(BIT_CYCLES_INT / 2);

  // Serial word layout
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned DAC_BITS  = 14;
  localparam int unsigned DAC_LSB   = 2;
  localparam int unsigned CTRL_HI   = 1;
  localparam int unsigned CTRL_LO   = 0;
  localparam logic [BITN_W-1:0] BITN_LAST = BITN_W'(WORD_BITS - 1);

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PHASE  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ADC    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_DAC    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_SEC    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

  // Field positions
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned ST_AVAIL_BIT     = 0;
  localparam int unsigned ST_OVERRUN_BIT   = 1;
  localparam int unsigned ST_SEC_PEND_BIT  = 2;
  localparam int unsigned ST_DIR_LSB       = 4;
  localparam int unsigned DAC_VALID_BIT    = 31;

  // Reset values and bus answers
  localparam logic [PHASE_W-1:0]   PHASE_RST   = 8'h00;
  localparam logic [WORD_BITS-1:0] ADC_RST     = 16'h0000;
  localparam logic [1:0]           RESP_OKAY   = 2'h0;
  localparam logic [1:0]           RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {DIR_NONE, DIR_LATER, DIR_EARLIER} dir_e;
  typedef enum logic [1:0] {ENG_IDLE, ENG_SYNC, ENG_SHIFT} eng_e;

  typedef struct packed {
    dir_e dir;
    logic sec;
  } decode_s;
endpackage : codec_pkg
`default_nettype wire

// *** hdl/codec_stream_if.sv ***
// Valid/ready word stream between the decoder and its buffer
`timescale 1ns/1ns
`default_nettype none
interface codec_stream_if #(parameter int unsigned W = 14);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : codec_stream_if
`default_nettype wire

// *** hdl/word_buffer2.sv ***
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_buffer2 #(
  parameter int unsigned DW = 14
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  codec_stream_if.snk fill,
  codec_stream_if.src drain
);
  typedef struct packed {
    logic [1:0][DW-1:0] mem;
    logic [1:0]         count;
    logic               wptr;
    logic               rptr;
  } buf_s;

  buf_s st_reg;
  buf_s st_next;

  logic do_wr;
  logic do_rd;

  // Full refuses the writer, empty shows nothing to the reader
  assign fill.ready  = (st_reg.count != 2'h2);
  assign drain.valid = (st_reg.count != 2'h0);
  assign drain.data  = st_reg.mem[st_reg.rptr];
  assign do_wr       = fill.valid & fill.ready;
  assign do_rd       = drain.valid & drain.ready;

  // Pointer and count update; simultaneous push and pop keeps the count
  always_comb begin
    st_next = st_reg;
    if (do_wr) begin
      st_next.mem[st_reg.wptr] = fill.data;
      st_next.wptr             = ~st_reg.wptr;
    end
    if (do_rd) begin
      st_next.rptr = ~st_reg.rptr;
    end
    if (do_wr && !do_rd) begin
      st_next.count = st_reg.count + 2'h1;
    end else if (do_rd && !do_wr) begin
      st_next.count = st_reg.count - 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : word_buffer2
`default_nettype wire

// *** hdl/codec_frame_control_decode.sv ***
// Codec serial port frame engine with primary control bit decode
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module codec_frame_control_decode
  import codec_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYCLES_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sclk,
  output logic             frame_sync_n,
  output logic             dout,
  input  wire logic        din,
  input  wire logic        func_ctrl_pin_lo,
  input  wire logic        func_ctrl_pin_hi
);
  localparam logic [FCNT_W-1:0] FRAME_LEN = FCNT_W'(FRAME_CYCLES);
  localparam logic [FCNT_W-1:0] HALF_LEN  = FCNT_W'(FRAME_CYCLES / 2);

  typedef struct packed {
    logic                 aw_full;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_full;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 enable;
    logic [PHASE_W-1:0]   phase;
    logic [WORD_BITS-1:0] adc_word;
    logic [WORD_BITS-1:0] sec_word;
    logic                 overrun;
    dir_e                 last_dir;
    eng_e                 eng;
    logic                 sec_kind;
    logic [DIV_W-1:0]     div;
    logic [BITN_W-1:0]    bitn;
    logic [WORD_BITS-1:0] tx_sh;
    logic [WORD_BITS-1:0] rx_sh;
    logic [FCNT_W-1:0]    fcnt;
    logic [FCNT_W-1:0]    flen;
    logic                 sec_pend;
    logic                 fs_active;
    logic                 sclk;
    logic                 dout;
    logic                 push;
    logic [DAC_BITS-1:0]  push_data;
  } state_s;

  state_s st_reg;
  state_s st_next;

  codec_stream_if #(.W(DAC_BITS)) fill_if ();
  codec_stream_if #(.W(DAC_BITS)) drain_if ();

  logic            wr_go;
  logic            rd_go;
  logic [ADDR_W-1:0] rd_addr;

  // Decode of the two low control bits against the two function pins
  function automatic decode_s decode_ctrl(input logic [1:0] bits,
                                          input logic [1:0] pins);
    decode_s d;
    d.dir = DIR_NONE;
    d.sec = 1'b0;
    case ({bits, pins})
      4'h1: d.dir = DIR_LATER;
      4'h2: d.dir = DIR_EARLIER;
      4'h3: d.sec = 1'b1;
      4'h4: d.dir = DIR_LATER;
      4'h7: begin
        d.dir = DIR_LATER;
        d.sec = 1'b1;
      end
      4'h8: d.dir = DIR_EARLIER;
      4'hB: begin
        d.dir = DIR_EARLIER;
        d.sec = 1'b1;
      end
      4'hC: d.sec = 1'b1;
      4'hD: begin
        d.dir = DIR_LATER;
        d.sec = 1'b1;
      end
      4'hE: begin
        d.dir = DIR_EARLIER;
        d.sec = 1'b1;
      end
      4'hF: d.sec = 1'b1;
      default: d.dir = DIR_NONE;
    endcase
    return d;
  endfunction : decode_ctrl

  // Length of the frame under way after a shift; phase is signed
  function automatic logic [FCNT_W-1:0] shifted_len(input dir_e dir,
                                    input logic [PHASE_W-1:0] ph);
    logic signed [FCNT_W:0] base;
    logic signed [FCNT_W:0] delta;
    logic signed [FCNT_W:0] sum;
    base  = $signed({1'b0, FRAME_LEN});
    delta = (FCNT_W + 1)'($signed(ph));
    sum   = base;
    if (dir == DIR_LATER) begin
      sum = base + delta;
    end else if (dir == DIR_EARLIER) begin
      sum = base - delta;
    end
    return sum[FCNT_W-1:0];
  endfunction : shifted_len

  // Byte-lane merge for partial register writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  word_buffer2 #(.DW(DAC_BITS)) u_buf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fill    (fill_if.snk),
    .drain   (drain_if.src)
  );

  // Bus handshakes; one write and one read under way at a time
  assign s_axi_awready = !st_reg.aw_full && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_full && !st_reg.bvalid;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign wr_go         = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign rd_addr       = s_axi_araddr[ADDR_W-1:0];

  // Reading the DAC register pops one word from the buffer
  assign drain_if.ready = rd_go && (rd_addr == REG_DAC) && drain_if.valid;
  assign fill_if.valid  = st_reg.push;
  assign fill_if.data   = st_reg.push_data;

  // Serial pins straight from flip-flops
  assign sclk         = st_reg.sclk;
  assign frame_sync_n = ~st_reg.fs_active;
  assign dout         = st_reg.dout;

  always_comb begin
    decode_s dec;
    logic [31:0] merged;
    logic [WORD_BITS-1:0] word;
    dec    = '0;
    merged = '0;
    word   = '0;
    st_next = st_reg;

    // Write channels are taken in either order and held until both arrive
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr[ADDR_W-1:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // Register write; unmapped offsets answer with a slave error
    if (wr_go) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OKAY;
      if (st_reg.aw_addr == REG_CTRL) begin
        merged = merge_bytes({31'h0, st_reg.enable}, st_reg.w_data,
                             st_reg.w_strb);
        st_next.enable = merged[CTRL_EN_BIT];
      end else if (st_reg.aw_addr == REG_PHASE) begin
        merged = merge_bytes({24'h0, st_reg.phase}, st_reg.w_data,
                             st_reg.w_strb);
        st_next.phase = merged[PHASE_W-1:0];
      end else if (st_reg.aw_addr == REG_ADC) begin
        merged = merge_bytes({16'h0, st_reg.adc_word}, st_reg.w_data,
                             st_reg.w_strb);
        st_next.adc_word = merged[WORD_BITS-1:0];
      end else if (st_reg.aw_addr == REG_STATUS) begin
        // Write one to clear the overrun flag
        if (st_reg.w_strb[0] && st_reg.w_data[ST_OVERRUN_BIT]) begin
          st_next.overrun = 1'b0;
        end
      end else if (st_reg.aw_addr == REG_DAC || st_reg.aw_addr == REG_SEC) begin
        st_next.bresp = RESP_OKAY;                  // Read-only, write dropped
      end else begin
        st_next.bresp = RESP_SLVERR;
      end
    end

    // Register read; data is captured at acceptance and held
    if (rd_go) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = '0;
      if (rd_addr == REG_CTRL) begin
        st_next.rdata[CTRL_EN_BIT] = st_reg.enable;
      end else if (rd_addr == REG_PHASE) begin
        st_next.rdata[PHASE_W-1:0] = st_reg.phase;
      end else if (rd_addr == REG_ADC) begin
        st_next.rdata[WORD_BITS-1:0] = st_reg.adc_word;
      end else if (rd_addr == REG_DAC) begin
        st_next.rdata[DAC_VALID_BIT]  = drain_if.valid;
        st_next.rdata[DAC_BITS-1:0]   = drain_if.valid ? drain_if.data : '0;
      end else if (rd_addr == REG_SEC) begin
        st_next.rdata[WORD_BITS-1:0] = st_reg.sec_word;
      end else if (rd_addr == REG_STATUS) begin
        st_next.rdata[ST_AVAIL_BIT]      = drain_if.valid;
        st_next.rdata[ST_OVERRUN_BIT]    = st_reg.overrun;
        st_next.rdata[ST_SEC_PEND_BIT]   = st_reg.sec_pend;
        st_next.rdata[ST_DIR_LSB +: 2]   = st_reg.last_dir;
      end else begin
        st_next.rresp = RESP_SLVERR;
      end
    end

    // A pending word leaves when the buffer takes it; full holds it back
    if (st_reg.push && fill_if.ready) begin
      st_next.push = 1'b0;
    end

    // Frame counter; the phase shift affects only the frame under way
    if (!st_reg.enable) begin
      st_next.fcnt     = '0;
      st_next.flen     = FRAME_LEN;
      st_next.sec_pend = 1'b0;
    end else if (st_reg.fcnt >= st_reg.flen - FCNT_W'(1)) begin
      st_next.fcnt = '0;
      st_next.flen = FRAME_LEN;
    end else begin
      st_next.fcnt = st_reg.fcnt + FCNT_W'(1);
    end

    // Serial word engine: one bit slot of sync, then sixteen data bits
    case (st_reg.eng)
      ENG_IDLE: begin
        st_next.sclk = 1'b0;
        if (st_reg.enable && st_reg.fcnt == '0) begin
          st_next.eng       = ENG_SYNC;
          st_next.sec_kind  = 1'b0;
          st_next.fs_active = 1'b1;
          st_next.div       = '0;
          st_next.tx_sh     = st_reg.adc_word;
        end else if (st_reg.enable && st_reg.sec_pend &&
                     st_reg.fcnt == HALF_LEN) begin
          st_next.eng       = ENG_SYNC;
          st_next.sec_kind  = 1'b1;
          st_next.sec_pend  = 1'b0;
          st_next.fs_active = 1'b1;
          st_next.div       = '0;
          st_next.tx_sh     = '0;
        end
      end
      ENG_SYNC: begin
        st_next.sclk = (st_reg.div < BIT_HALF);
        st_next.div  = st_reg.div + DIV_W'(1);
        if (st_reg.div == BIT_LAST) begin
          st_next.eng       = ENG_SHIFT;
          st_next.fs_active = 1'b0;
          st_next.div       = '0;
          st_next.bitn      = '0;
          st_next.dout      = st_reg.tx_sh[WORD_BITS-1];
        end
      end
      ENG_SHIFT: begin
        st_next.sclk = (st_reg.div < BIT_HALF);
        st_next.div  = st_reg.div + DIV_W'(1);
        // Sample din mid-bit, away from the edges where it changes
        if (st_reg.div == BIT_HALF) begin
          st_next.rx_sh = {st_reg.rx_sh[WORD_BITS-2:0], din};
        end
        if (st_reg.div == BIT_LAST) begin
          st_next.div = '0;
          if (st_reg.bitn == BITN_LAST) begin
            st_next.eng  = ENG_IDLE;
            st_next.dout = 1'b0;
            word = st_reg.rx_sh;
            if (st_reg.sec_kind) begin
              st_next.sec_word = word;
            end else begin
              // Data to the buffer; an unsent older word is an overrun
              if (st_reg.push && !fill_if.ready) begin
                st_next.overrun = 1'b1;
              end
              st_next.push      = 1'b1;
              st_next.push_data = word[DAC_LSB +: DAC_BITS];
              dec = decode_ctrl({word[CTRL_HI], word[CTRL_LO]},
                                {func_ctrl_pin_hi, func_ctrl_pin_lo});
              st_next.last_dir = dec.dir;
              st_next.flen = shifted_len(dec.dir, st_reg.phase);
              st_next.sec_pend = dec.sec;
            end
          end else begin
            st_next.bitn  = st_reg.bitn + BITN_W'(1);
            st_next.tx_sh = {st_reg.tx_sh[WORD_BITS-2:0], 1'b0};
            st_next.dout  = st_reg.tx_sh[WORD_BITS-2];
          end
        end
      end
      default: st_next.eng = ENG_IDLE;
    endcase
  end

  // Synchronous reset clears all state; sync output idles high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : codec_frame_control_decode
`default_nettype wire

// *** tb/codec_frame_monitor.sv ***
// Port checker for the codec frame control decoder
`timescale 1ns/1ns
`default_nettype none
module codec_frame_monitor #(
  parameter int unsigned FRAME_CYCLES = 600
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       sclk,
  input wire logic       frame_sync_n
);
  logic        sync_reg;
  logic [15:0] gap_reg;

  // Cycles since the last sync fall; saturates so long idle never wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg <= 1'b1;
      gap_reg  <= 16'hFFFF;
    end else begin
      sync_reg <= frame_sync_n;
      if (sync_reg && !frame_sync_n) gap_reg <= 16'h0001;
      else if (gap_reg != 16'hFFFF) gap_reg <= gap_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence slot_high; sclk [*4]; endsequence
  sequence slot_low; !sclk [*4]; endsequence
  sequence sync_slot; !frame_sync_n [*8] ##1 frame_sync_n; endsequence

  AST_SYNC_SLOT: assert property ($fell(frame_sync_n) |-> sync_slot)
    else $error("sync low time wrong");
  AST_SCLK_SLOT: assert property ($rose(sclk) |-> slot_high ##1 slot_low)
    else $error("bit clock slot shape wrong");
  // A frame must finish its word before the next sync, and never stall
  AST_FRAME_GAP: assert property ((sync_reg && !frame_sync_n) |->
    gap_reg >= 16'h0088 && (gap_reg == 16'hFFFF ||
    gap_reg <= FRAME_CYCLES * 3 / 2)) else $error("sync spacing wrong");
  AST_WRITE_ANSWER: assert property ((s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready) |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_BRESP_HOLD: assert property ((s_axi_bvalid && !s_axi_bready) |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  AST_READ_ANSWER: assert property ((s_axi_arvalid && s_axi_arready) |=>
    s_axi_rvalid) else $error("read data late");
  AST_AW_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response waits");
  AST_AR_BLOCKED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data waits");
endmodule : codec_frame_monitor
`default_nettype wire

// *** tb/codec_dsp_model.sv ***
// Behavioural DSP serial port facing the codec frame engine
`timescale 1ns/1ns
`default_nettype none
module codec_dsp_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        sclk,
  input  wire logic        frame_sync_n,
  input  wire logic        dout,
  input  wire logic [15:0] word_in,
  output logic             din,
  output logic [15:0]      adc_word,
  output logic             adc_done
);
  logic        sclk_reg;
  logic        sync_reg;
  logic        busy;
  logic [15:0] tx_reg;
  logic [15:0] rx_reg;
  logic [4:0]  idx_reg;

  assign busy = idx_reg != 5'h00 && idx_reg != 5'h11;

  // One word per frame MSB first; outside a word din toggles every cycle
  // so a stray sample never sees a steady stale bit
  always @(posedge aclk) begin
    sclk_reg <= sclk;
    sync_reg <= frame_sync_n;
    adc_done <= 1'b0;
    if (!aresetn) begin
      idx_reg <= 5'h11;
      din     <= 1'b0;
    end else if (sync_reg && !frame_sync_n) begin
      tx_reg  <= word_in;
      idx_reg <= 5'h00;
      din     <= ~din;
    end else if (sclk && !sclk_reg && frame_sync_n && idx_reg < 5'h10) begin
      din     <= tx_reg[4'hF - idx_reg[3:0]];
      idx_reg <= idx_reg + 5'h01;
    end else if (!sclk && sclk_reg && busy) begin
      rx_reg <= {rx_reg[14:0], dout};
      if (idx_reg == 5'h10) begin
        adc_word <= {rx_reg[14:0], dout};
        adc_done <= 1'b1;
        idx_reg  <= 5'h11;
      end
    end else if (!busy) begin
      din <= ~din;
    end
  end
endmodule : codec_dsp_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the codec frame control decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin \
  mismatches++; $display("BAD %s exp %0h got %0h", nm, e, a); end end
module tb_top;
  import codec_pkg::*;
  localparam int FC = 600;
  int          seed, mismatches, check_count, gap;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, sclk, dout, din;
  logic        frame_sync_n, func_ctrl_pin_lo, func_ctrl_pin_hi, adc_done;
  logic        started, sync_q;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] word_in, adc_word, adc;
  logic [15:0] wq [4];
  logic [7:0]  ph;
  int          iexp [$];
  logic [15:0] aexp [$];
  logic [33:0] rexp [$];
  logic [31:0] rmsk [$];
  logic [1:0]  bexp [$];

  codec_frame_control_decode #(.FRAME_CYCLES(FC)) uut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sclk, .frame_sync_n, .dout, .din,
    .func_ctrl_pin_lo, .func_ctrl_pin_hi);
  codec_dsp_model dsp (.aclk, .aresetn, .sclk, .frame_sync_n, .dout,
    .word_in, .din, .adc_word, .adc_done);

  always #5 aclk = ~aclk;

  // Watchers: each result takes the oldest note off its queue
  always @(posedge aclk) begin
    logic [33:0] r;
    logic [31:0] m;
    logic [15:0] a;
    logic [1:0]  b;
    int          g;
    sync_q <= frame_sync_n;
    gap    <= gap + 1;
    if (s_axi_bvalid && s_axi_bready) begin
      b = bexp.pop_front();
      `CHK("bresp", b, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      r = rexp.pop_front();
      m = rmsk.pop_front();
      `CHK("rresp", r[33:32], s_axi_rresp)
      `CHK("rdata", r[31:0] & m, s_axi_rdata & m)
    end
    if (adc_done) begin
      a = aexp.pop_front();
      `CHK("adc", a, adc_word)
    end
    if (sync_q && !frame_sync_n) begin
      gap <= 1;
      if (started) begin
        g = iexp.pop_front();
        if (g == FC / 2) `CHK("sec gap", g, gap)
        else `CHK("gap", g, gap)
      end
      started <= 1'b1;
    end
  end

  // Write: both channels offered together, each released once taken
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d,
                        input logic [1:0] er);
    bexp.push_back(er);
    s_axi_awaddr <= {24'h000000, ad};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(negedge aclk); while (!s_axi_awready);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (!s_axi_wready);
        @(posedge aclk);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] ad, input logic [31:0] e, m,
                        input logic [1:0] er);
    rexp.push_back({er, e});
    rmsk.push_back(m);
    s_axi_araddr <= {24'h000000, ad};
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    @(posedge aclk);
  endtask : axi_rd

  // One primary frame; pins change only after the last frame's decode
  task automatic run_case(input logic [1:0] b, input logic [1:0] pn);
    logic [15:0] w;
    logic        ign, sec;
    logic [1:0]  dir;
    int          s;
    w = 16'($random(seed));
    w[1:0] = b;
    ign = (^b) && (^pn);
    sec = !ign && (&b || &pn);
    dir = 2'h0;
    if (!ign && (b == 2'h1 || pn == 2'h1)) dir = 2'h1;
    if (!ign && (b == 2'h2 || pn == 2'h2)) dir = 2'h2;
    s = (dir == 2'h1) ? int'($signed(ph)) : 0;
    if (dir == 2'h2) s = -int'($signed(ph));
    word_in <= w;
    {func_ctrl_pin_hi, func_ctrl_pin_lo} <= pn;
    @(negedge frame_sync_n);
    aexp.push_back(adc);
    if (sec) begin
      iexp.push_back(FC / 2);
      iexp.push_back(FC / 2 + s);
      aexp.push_back(16'h0000);
    end else begin
      iexp.push_back(FC + s);
    end
    repeat (145) @(posedge aclk);
    axi_rd(REG_DAC, {1'b1, 17'h00000, w[15:2]}, 32'h80003FFF, RESP_OKAY);
    axi_rd(REG_STATUS, {26'h0000000, dir, 4'h0}, 32'h00000030, RESP_OKAY);
    if (sec) begin
      @(negedge frame_sync_n);
      repeat (145) @(posedge aclk);
      axi_rd(REG_SEC, {16'h0000, w}, 32'h0000FFFF, RESP_OKAY);
    end
  endtask : run_case

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run is near 22k cycles; over four times that means a hang
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish;
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h01;
    {s_axi_arvalid, s_axi_rready, func_ctrl_pin_lo, func_ctrl_pin_hi} = 4'h4;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {word_in, ph, started, sync_q} = 26'h0000001;
    s_axi_wstrb = 4'hF;
    seed = 32'h5A79;
    mismatches = 0;
    check_count = 0;
    gap = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(REG_PHASE, 32'h0, 32'h000000FF, RESP_OKAY);
    axi_rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
    adc = 16'($random(seed));
    axi_wr(REG_ADC, {16'h0000, adc}, RESP_OKAY);
    axi_wr(REG_DAC, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(REG_DAC, 32'h0, 32'h80000000, RESP_OKAY);
    iexp.push_back(FC);
    aexp.push_back(adc);
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    repeat (150) @(posedge aclk);
    axi_rd(REG_CTRL, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(REG_DAC, 32'h80000000, 32'h80003FFF, RESP_OKAY);
    // Every bit and pin combination, positive then negative phase
    for (int p = 0; p < 2; p++) begin
      ph = p ? 8'hD3 : 8'h25;
      axi_wr(REG_PHASE, {24'h000000, ph}, RESP_OKAY);
      for (int c = 0; c < 16; c++) run_case(2'(c >> 2), 2'(c));
    end
    // Leave four words unread: two buffered, one pending, one overrun
    for (int k = 0; k < 4; k++) begin
      wq[k] = 16'($random(seed)) & 16'hFFFC;
      word_in <= wq[k];
      {func_ctrl_pin_hi, func_ctrl_pin_lo} <= 2'h0;
      @(negedge frame_sync_n);
      iexp.push_back(FC);
      aexp.push_back(adc);
      repeat (145) @(posedge aclk);
    end
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h2, 32'h2, RESP_OKAY);
    axi_rd(REG_DAC, {16'h8000, 2'h0, wq[0][15:2]}, 32'h80003FFF, RESP_OKAY);
    axi_rd(REG_DAC, {16'h8000, 2'h0, wq[1][15:2]}, 32'h80003FFF, RESP_OKAY);
    axi_rd(REG_DAC, {16'h8000, 2'h0, wq[3][15:2]}, 32'h80003FFF, RESP_OKAY);
    axi_rd(REG_DAC, 32'h0, 32'h80000000, RESP_OKAY);
    axi_wr(REG_STATUS, 32'h2, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h0, 32'h2, RESP_OKAY);
    tally_and_finish;
  end
endmodule : tb_top

bind codec_frame_control_decode codec_frame_monitor #(
  .FRAME_CYCLES(FRAME_CYCLES)) mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sclk,
  .frame_sync_n);
`default_nettype wire
